// ===== lcf_consts.vh
// constants for the link control field handler: register offsets,
// control field encodings, address kinds, precedence and timing.
// assumes inclusion by bare name from every design file.
`ifndef LCF_CONSTS_VH
`define LCF_CONSTS_VH
// register indices on the plain register port
`define REG_CTRL 4'h0
`define REG_TOL 4'h1
`define REG_OWN 4'h2
`define REG_STAT 4'h3
`define REG_DUPS 4'h4
`define REG_DISC 4'h5
// control register field positions
`define CTRL_BUSY 0
`define CTRL_SEND_RR 1
`define CTRL_SEND_NR 2
`define CTRL_KIND_LO 4
// reset values
`define RST_TOL 16'h0064
`define RST_OWN 8'h02
// connectionless control fields, bit 1 of the field in bit 0
`define CF_UI 8'h03
`define CF_RR_CMD 8'h23
`define CF_RR_RSP 8'h33
`define CF_NR_CMD 8'h0b
`define CF_NR_RSP 8'h1b
`define CF_TEST 8'he3
`define CF_PF_MASK 8'h10
// command/response bit values of a command and of a response in the source address
`define CR_CMD 1'b0
`define CR_RSP 1'b1
// destination address kinds
`define KIND_IND 2'h0
`define KIND_SPC 2'h1
`define KIND_GRP 2'h2
`define KIND_GLB 2'h3
// precedence, larger is more urgent
`define PREC_MID 2'h1
// test information field limit in octets
`define TEST_MAX_OCT 8'h80
// time stamp tick and its cycle count at 10 mhz
`define TICK_NS 100000
`define CLK_NS 100
`define TICK_CYC ((`TICK_NS + `CLK_NS - 1) / `CLK_NS)
`define ACK_TICKS 16'h03e8
`endif

// ===== ctrl_decode.v
// connectionless control field decoder, purely combinational.
// assumes the field arrives with its first sent bit in bit 0.
`default_nettype none
`include "lcf_consts.vh"
module ctrl_decode (
	// field in
	input wire [7:0] cf,
	// decoded kind
	output wire is_ui,
	output wire is_rr_cmd,
	output wire is_rr_rsp,
	output wire is_nr_cmd,
	output wire is_nr_rsp,
	output wire is_test,
	output wire pf,
	output wire known
);
	wire [7:0] base;
	assign base = cf & ~`CF_PF_MASK;
	assign pf = cf[4];
	assign is_ui = (base == `CF_UI);
	assign is_rr_cmd = (cf == `CF_RR_CMD);
	assign is_rr_rsp = (cf == `CF_RR_RSP);
	assign is_nr_cmd = (cf == `CF_NR_CMD);
	assign is_nr_rsp = (cf == `CF_NR_RSP);
	assign is_test = (base == `CF_TEST);
	assign known = is_ui | is_rr_cmd | is_rr_rsp | is_nr_cmd | is_nr_rsp |
		is_test;
endmodule // ctrl_decode
`default_nettype wire

// ===== ctrl_shifter.v
// least significant bit first shifter for 8 or 16 bit control fields.
// assumes load is only honoured while idle.
`default_nettype none
`include "lcf_consts.vh"
module ctrl_shifter (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// load side
	input wire load,
	input wire [15:0] ld_data,
	input wire ld_len16,
	// bit stream out
	output reg bit_out,
	output reg bit_valid,
	output reg busy
);
	reg [15:0] sh_r;
	reg [4:0] cnt_r;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_r <= 16'h0000;
			cnt_r <= 5'h00;
			bit_out <= 1'b0;
			bit_valid <= 1'b0;
			busy <= 1'b0;
		end else if (load && !busy) begin
			sh_r <= ld_data;
			cnt_r <= ld_len16 ? 5'h10 : 5'h08;
			busy <= 1'b1;
			bit_valid <= 1'b0;
		end else if (busy) begin
			bit_out <= sh_r[0];
			bit_valid <= 1'b1;
			sh_r <= {1'b0, sh_r[15:1]};
			cnt_r <= cnt_r - 5'h01;
			busy <= (cnt_r != 5'h01);
		end else begin
			bit_valid <= 1'b0;
		end
	end
endmodule // ctrl_shifter
`default_nettype wire

// ===== link_control_field_handler.v
// link control field handler: connectionless control field decode and
// answer, acked connectionless duplicate filter, urgent response slot,
// numbered info field builder and lsb first control field shifter.
// assumes rx descriptors and tx takes come from logic on clk.
`default_nettype none
`include "lcf_consts.vh"
module link_control_field_handler #(
	parameter LOG_N = 8,
	parameter TW = 16,
	parameter MAX_ADDR = 8,
	parameter [15:0] ACK_TICKS = `ACK_TICKS
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// register port
	input wire [3:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	// received unit, one pulse per destination address
	input wire rx_valid,
	input wire rx_first,
	input wire [7:0] rx_src,
	input wire [7:0] rx_dst,
	input wire [1:0] rx_kind,
	input wire [7:0] rx_ctrl,
	input wire rx_acked,
	input wire [7:0] rx_id,
	input wire [1:0] rx_prec,
	input wire [7:0] rx_info_len,
	input wire rx_info_ok,
	// receive verdict
	output reg rx_accept,
	output reg rx_discard,
	output reg rx_dup,
	output reg rx_is_cmd,
	output reg peer_busy,
	// transmit queue state
	input wire [1:0] q_max_prec,
	input wire q_fpo_pending,
	// urgent response slot
	input wire resp_take,
	output reg resp_valid,
	output reg [7:0] resp_ctrl,
	output reg [7:0] resp_src,
	output reg [7:0] resp_dst,
	output reg [1:0] resp_prec,
	output reg resp_echo,
	output reg resp_hold,
	output reg resp_after_fpo,
	// delivery receipt request
	input wire drr_take,
	output reg drr_valid,
	output reg [7:0] drr_dst,
	output reg [7:0] drr_id,
	output reg [1:0] drr_prec,
	// ready and not ready commands
	input wire cmd_take,
	output reg cmd_valid,
	output reg [7:0] cmd_ctrl,
	output reg [7:0] cmd_src,
	output reg [1:0] cmd_kind,
	// numbered info field builder
	input wire ni_req,
	input wire [6:0] ni_ns,
	input wire [6:0] ni_nr,
	input wire ni_pf,
	input wire ni_group,
	output reg [15:0] ni_ctrl,
	// serial control field
	output wire ser_bit,
	output wire ser_valid,
	output wire ser_busy
);
	localparam [31:0] TOL_FULL = 3 * ACK_TICKS;
	localparam [TW-1:0] TOL_MAX = TOL_FULL[TW-1:0];
	localparam [31:0] TICK_FULL = `TICK_CYC - 1;
	localparam [9:0] TICK_LAST = TICK_FULL[9:0];
	// registers
	reg busy_r, busy_d_r;
	reg [1:0] kind_r;
	reg [TW-1:0] tol_r;
	reg [7:0] own_r;
	reg [15:0] dups_r, disc_r;
	// time base
	reg [9:0] tick_r;
	reg [TW-1:0] now_r;
	// duplicate log
	reg [LOG_N-1:0] lv_r;
	reg [7:0] la_r [0:LOG_N-1];
	reg [7:0] li_r [0:LOG_N-1];
	reg [TW-1:0] lt_r [0:LOG_N-1];
	reg [2:0] wp_r;
	// multi address bookkeeping
	reg [7:0] f_ctrl_r;
	reg [7:0] seen_r [0:MAX_ADDR-1];
	reg [3:0] nseen_r;
	reg f_bad_r;
	integer i;
	function [TW-1:0] age;
		input [TW-1:0] t;
		begin
			age = now_r - t;
		end
	endfunction
	// decode of the incoming field
	wire d_ui, d_rrc, d_rrr, d_nrc, d_nrr, d_test, d_pf, d_known;
	ctrl_decode u_dec (
		.cf(rx_ctrl),
		.is_ui(d_ui),
		.is_rr_cmd(d_rrc),
		.is_rr_rsp(d_rrr),
		.is_nr_cmd(d_nrc),
		.is_nr_rsp(d_nrr),
		.is_test(d_test),
		.pf(d_pf),
		.known(d_known)
	);
	reg hit;
	reg seen_hit;
	always @* begin
		hit = 1'b0;
		seen_hit = 1'b0;
		for (i = 0; i < LOG_N; i = i + 1)
			if (lv_r[i] && la_r[i] == rx_src && li_r[i] == rx_id &&
				age(lt_r[i]) <= tol_r)
				hit = 1'b1;
		for (i = 0; i < MAX_ADDR; i = i + 1)
			if (i < nseen_r && seen_r[i] == rx_dst)
				seen_hit = 1'b1;
	end
	// command when source lsb is clear
	wire is_cmd = (rx_src[0] == `CR_CMD);
	wire ind = (rx_kind == `KIND_IND);
	// same type and no repeated individual address
	wire mix_bad = !rx_first &&
		(f_bad_r || ((rx_ctrl ^ f_ctrl_r) & ~`CF_PF_MASK) != 8'h00 ||
		(ind && seen_hit));
	wire test_big = d_test && rx_info_len > `TEST_MAX_OCT;
	wire t1_bad = !rx_acked && (!d_known || test_big);
	wire drop = mix_bad || t1_bad || (rx_acked && hit);
	// response generation
	reg r_new, r_echo, r_hold;
	reg [7:0] r_ctrl;
	always @* begin
		r_new = 1'b0;
		r_echo = 1'b0;
		r_hold = 1'b0;
		r_ctrl = `CF_RR_RSP;
		if (rx_valid && !drop && !rx_acked && is_cmd) begin
			if (d_ui && d_pf && ind) begin
				r_new = 1'b1;
				r_hold = 1'b1;
				// ready response, not ready when busy
				r_ctrl = busy_r ? `CF_NR_RSP : `CF_RR_RSP;
			end else if (d_test && d_pf && ind) begin
				r_new = 1'b1;
				r_hold = 1'b1;
				r_ctrl = `CF_TEST | `CF_PF_MASK;
			end else if (d_test && !d_pf) begin
				// echo field if it can be taken
				r_new = 1'b1;
				r_echo = rx_info_ok && rx_info_len != 8'h00;
				r_ctrl = `CF_TEST;
			end
			// polled test to group or global: no answer
		end
	end
	wire refuse = busy_r && (d_ui || rx_acked);
	wire w_ctrl = reg_wr && reg_addr == `REG_CTRL;
	wire cmd_rr = (w_ctrl && reg_wdata[`CTRL_SEND_RR]) ||
		(busy_d_r && !busy_r);
	wire cmd_nr = (w_ctrl && reg_wdata[`CTRL_SEND_NR]) ||
		(!busy_d_r && busy_r);
	// precedence is the greater of queued and mid
	wire [1:0] up_prec = (q_max_prec > `PREC_MID) ? q_max_prec :
		`PREC_MID;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			busy_d_r <= 1'b0;
			kind_r <= `KIND_GLB;
			tol_r <= `RST_TOL;
			own_r <= `RST_OWN;
			reg_rdata <= 16'h0000;
		end else begin
			busy_d_r <= busy_r;
			if (w_ctrl) begin
				busy_r <= reg_wdata[`CTRL_BUSY];
				kind_r <= reg_wdata[`CTRL_KIND_LO+1:`CTRL_KIND_LO];
			end
			// tolerance clamped to three ack timers
			if (reg_wr && reg_addr == `REG_TOL)
				tol_r <= (reg_wdata[TW-1:0] > TOL_MAX) ? TOL_MAX :
					reg_wdata[TW-1:0];
			if (reg_wr && reg_addr == `REG_OWN)
				own_r <= {reg_wdata[7:1], 1'b0};
			reg_rdata <= 16'h0000;
			if (reg_rd) begin
				case (reg_addr)
				`REG_CTRL: reg_rdata <= {10'h000, kind_r, 3'h0, busy_r};
				`REG_TOL: reg_rdata <= tol_r;
				`REG_OWN: reg_rdata <= {8'h00, own_r};
				`REG_STAT: reg_rdata <= {12'h000, ser_busy, peer_busy,
					cmd_valid, resp_valid};
				`REG_DUPS: reg_rdata <= dups_r;
				`REG_DISC: reg_rdata <= disc_r;
				default: reg_rdata <= 16'h0000;
				endcase
			end
		end
	end
	// time base and duplicate log
	always @(posedge clk or negedge rst_n) begin : log_upd
		integer j;
		if (!rst_n) begin
			tick_r <= 10'h000;
			now_r <= {TW{1'b0}};
			lv_r <= {LOG_N{1'b0}};
			wp_r <= 3'h0;
			for (j = 0; j < LOG_N; j = j + 1) begin
				la_r[j] <= 8'h00;
				li_r[j] <= 8'h00;
				lt_r[j] <= {TW{1'b0}};
			end
		end else begin
			tick_r <= (tick_r == TICK_LAST) ? 10'h000 : tick_r + 10'h001;
			if (tick_r == TICK_LAST)
				now_r <= now_r + 1'b1;
			for (j = 0; j < LOG_N; j = j + 1)
				if (age(lt_r[j]) > tol_r)
					lv_r[j] <= 1'b0;
			// stamp arrival with address and id
			if (rx_valid && rx_acked && rx_first && !hit) begin
				la_r[wp_r] <= rx_src;
				li_r[wp_r] <= rx_id;
				lt_r[wp_r] <= now_r;
				lv_r[wp_r] <= 1'b1;
				wp_r <= wp_r + 3'h1;
			end
		end
	end
	// receive verdict and multi address tracking
	always @(posedge clk or negedge rst_n) begin : verdict_upd
		integer m;
		if (!rst_n) begin
			rx_accept <= 1'b0;
			rx_discard <= 1'b0;
			rx_dup <= 1'b0;
			rx_is_cmd <= 1'b0;
			peer_busy <= 1'b0;
			dups_r <= 16'h0000;
			disc_r <= 16'h0000;
			f_ctrl_r <= 8'h00;
			f_bad_r <= 1'b0;
			nseen_r <= 4'h0;
			for (m = 0; m < MAX_ADDR; m = m + 1)
				seen_r[m] <= 8'h00;
		end else begin
			rx_accept <= rx_valid && !drop && !refuse &&
				(rx_acked || d_ui || (d_test && !is_cmd));
			rx_discard <= rx_valid && (drop || refuse);
			rx_dup <= rx_valid && rx_acked && hit && !mix_bad;
			rx_is_cmd <= rx_valid && is_cmd;
			if (rx_valid && !drop && !rx_acked && (d_rrc || d_rrr))
				peer_busy <= 1'b0;
			if (rx_valid && !drop && !rx_acked && (d_nrc || d_nrr))
				peer_busy <= 1'b1;
			if (rx_valid && rx_acked && hit && !mix_bad)
				dups_r <= dups_r + 16'h0001;
			if (rx_valid && (drop || refuse))
				disc_r <= disc_r + 16'h0001;
			if (rx_valid) begin
				if (rx_first) begin
					f_ctrl_r <= rx_ctrl;
					f_bad_r <= 1'b0;
					seen_r[0] <= rx_dst;
					nseen_r <= 4'h1;
				end else begin
					f_bad_r <= mix_bad;
					if (nseen_r < MAX_ADDR) begin
						seen_r[nseen_r[2:0]] <= rx_dst;
						nseen_r <= nseen_r + 4'h1;
					end
				end
			end
		end
	end
	// response slot, delivery receipts and commands
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			resp_valid <= 1'b0;
			resp_ctrl <= 8'h00;
			resp_src <= 8'h00;
			resp_dst <= 8'h00;
			resp_prec <= 2'h0;
			resp_echo <= 1'b0;
			resp_hold <= 1'b0;
			resp_after_fpo <= 1'b0;
			drr_valid <= 1'b0;
			drr_dst <= 8'h00;
			drr_id <= 8'h00;
			drr_prec <= 2'h0;
			cmd_valid <= 1'b0;
			cmd_ctrl <= 8'h00;
			cmd_src <= 8'h00;
			cmd_kind <= 2'h0;
		end else begin
			if (resp_take)
				resp_valid <= 1'b0;
			if (r_new && (!resp_valid || resp_take)) begin
				resp_valid <= 1'b1;
				resp_ctrl <= r_ctrl;
				// own individual address, response bit set
				resp_src <= {own_r[7:1], `CR_RSP};
				resp_dst <= {rx_src[7:1], 1'b0};
				resp_prec <= up_prec;
				resp_echo <= r_echo;
				resp_hold <= r_hold;
				resp_after_fpo <= q_fpo_pending;
			end
			if (drr_take)
				drr_valid <= 1'b0;
			if (rx_valid && rx_acked && ind && !drop && !refuse &&
				(!drr_valid || drr_take)) begin
				drr_valid <= 1'b1;
				drr_dst <= {rx_src[7:1], 1'b0};
				drr_id <= rx_id;
				drr_prec <= rx_prec;
			end
			if (cmd_take)
				cmd_valid <= 1'b0;
			if ((cmd_rr || cmd_nr) && (!cmd_valid || cmd_take)) begin
				cmd_valid <= 1'b1;
				cmd_ctrl <= cmd_nr ? `CF_NR_CMD : `CF_RR_CMD;
				cmd_src <= {own_r[7:1], `CR_CMD};
				cmd_kind <= kind_r;
			end
		end
	end
	// numbered field, sequence numbers zero for group, shared base
	wire [15:0] ni_field = ni_group ? {7'h00, ni_pf, 8'h00} :
		{ni_nr, ni_pf, ni_ns, 1'b0};
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ni_ctrl <= 16'h0000;
		else if (ni_req)
			ni_ctrl <= ni_field;
	end
	// lsb first onto the physical layer
	wire sh_resp = resp_take && resp_valid;
	wire sh_cmd = cmd_take && cmd_valid && !sh_resp;
	wire sh_load = sh_resp || sh_cmd || ni_req;
	wire [15:0] sh_data = sh_resp ? {8'h00, resp_ctrl} :
		sh_cmd ? {8'h00, cmd_ctrl} : ni_field;
	ctrl_shifter u_sh (
		.clk(clk),
		.rst_n(rst_n),
		.load(sh_load),
		.ld_data(sh_data),
		.ld_len16(!sh_resp && !sh_cmd),
		.bit_out(ser_bit),
		.bit_valid(ser_valid),
		.busy(ser_busy)
	);
endmodule // link_control_field_handler
`default_nettype wire

// ===== lcf_props.sv
// checker watching the control field handler ports.
// assumes one clock clk and async active low reset rst_n.
`default_nettype none
`include "lcf_consts.vh"
module lcf_props (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// receive side
	input wire logic rx_valid,
	input wire logic rx_acked,
	input wire logic [7:0] rx_src,
	input wire logic [7:0] rx_ctrl,
	input wire logic [1:0] rx_kind,
	input wire logic [1:0] rx_prec,
	input wire logic rx_discard,
	input wire logic rx_is_cmd,
	// response and receipt slots
	input wire logic [1:0] q_max_prec,
	input wire logic resp_take,
	input wire logic resp_valid,
	input wire logic [7:0] resp_ctrl,
	input wire logic [7:0] resp_src,
	input wire logic [7:0] resp_dst,
	input wire logic [1:0] resp_prec,
	input wire logic drr_valid,
	input wire logic [1:0] drr_prec,
	// numbered field and shifter
	input wire logic ni_req,
	input wire logic [6:0] ni_ns,
	input wire logic [6:0] ni_nr,
	input wire logic ni_pf,
	input wire logic ni_group,
	input wire logic [15:0] ni_ctrl,
	input wire logic ser_bit,
	input wire logic ser_valid,
	input wire logic ser_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	function automatic logic known(input logic [7:0] c);
		known = c == `CF_UI || c == (`CF_UI | `CF_PF_MASK) ||
			c == `CF_RR_CMD || c == `CF_RR_RSP || c == `CF_NR_CMD ||
			c == `CF_NR_RSP || c == `CF_TEST || c == (`CF_TEST | `CF_PF_MASK);
	endfunction
	property p_is_cmd;
		rx_valid |=> rx_is_cmd == !$past(rx_src[0]);
	endproperty
	property p_unknown;
		rx_valid && !rx_acked && !known(rx_ctrl) |=> rx_discard;
	endproperty
	property p_prec;
		$rose(resp_valid) |-> resp_prec == ($past(q_max_prec) > `PREC_MID ?
			$past(q_max_prec) : `PREC_MID);
	endproperty
	property p_src;
		resp_valid |-> resp_src[0] && !resp_dst[0];
	endproperty
	property p_drr;
		$rose(drr_valid) |-> drr_prec == $past(rx_prec);
	endproperty
	property p_ni;
		ni_req && !ni_group |=> ni_ctrl == {$past(ni_nr), $past(ni_pf),
			$past(ni_ns), 1'b0};
	endproperty
	property p_group;
		ni_req && ni_group |=> ni_ctrl == {7'h00, $past(ni_pf), 8'h00};
	endproperty
	// shifter load, then the first two bits lsb first
	sequence s_shift;
		ser_busy ##1 (ser_valid && ser_bit == $past(resp_ctrl[0], 2))
			##1 (ser_valid && ser_bit == $past(resp_ctrl[1], 3));
	endsequence
	property p_ser;
		resp_take && resp_valid && !ser_busy |=> s_shift;
	endproperty
	property p_silent;
		rx_valid && !rx_acked && !rx_src[0] && rx_kind >= `KIND_GRP &&
			rx_ctrl == (`CF_TEST | `CF_PF_MASK) && !resp_valid |=> !resp_valid;
	endproperty
	a_is_cmd: assert property (p_is_cmd)
		else $error("command flag wrong");
	a_unknown: assert property (p_unknown)
		else $error("unknown field kept");
	a_prec: assert property (p_prec)
		else $error("response precedence wrong");
	a_src: assert property (p_src)
		else $error("response address bits wrong");
	a_drr: assert property (p_drr)
		else $error("receipt precedence wrong");
	a_ni: assert property (p_ni)
		else $error("numbered field wrong");
	a_group: assert property (p_group)
		else $error("group numbers not zero");
	a_ser: assert property (p_ser)
		else $error("serial order wrong");
	a_silent: assert property (p_silent)
		else $error("group polled test answered");
endmodule // lcf_props
bind link_control_field_handler lcf_props u_lcf_props (.*);
`default_nettype wire

// ===== peer_station.sv
// far side transmit queue: takes urgent responses, receipts, commands.
// assumes slot valids are levels held until the take pulse.
`default_nettype none
module peer_station (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control and slots
	input wire logic stall,
	input wire logic resp_valid,
	input wire logic drr_valid,
	input wire logic cmd_valid,
	output logic resp_take,
	output logic drr_take,
	output logic cmd_take
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] wait_r;
	logic any;
	assign any = resp_take | drr_take | cmd_take;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_r <= 2'h0;
			{resp_take, drr_take, cmd_take} <= 3'h0;
		end else begin
			wait_r <= (stall || any) ? 2'h0 : wait_r + 2'h1;
			{resp_take, drr_take, cmd_take} <= 3'h0;
			if (!stall && !any && wait_r == 2'h3) begin
				if (resp_valid) resp_take <= 1'b1;
				else if (drr_valid) drr_take <= 1'b1;
				else if (cmd_valid) cmd_take <= 1'b1;
			end
		end
	end
endmodule // peer_station
`default_nettype wire

// ===== tb_top.sv
// top testbench for the control field handler.
// assumes the peer model and the bound checker alongside.
`default_nettype none
`include "lcf_consts.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, stall = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, ni_ctrl;
	logic rx_valid = 1'b0, rx_first = 1'b0, rx_acked = 1'b0, rx_info_ok = 1'b1;
	logic [7:0] rx_src = 8'h00, rx_dst = 8'h00, rx_ctrl = 8'h00;
	logic [7:0] rx_id = 8'h05, rx_info_len = 8'h00;
	logic [1:0] rx_kind = 2'h0, rx_prec = 2'h2, q_max_prec = 2'h0;
	logic q_fpo_pending = 1'b0, ni_req = 1'b0, ni_pf = 1'b0, ni_group = 1'b0;
	logic [6:0] ni_ns = 7'h00, ni_nr = 7'h00;
	logic rx_accept, rx_discard, rx_dup, rx_is_cmd, peer_busy, resp_take;
	logic resp_valid, resp_echo, resp_hold, resp_after_fpo, drr_take;
	logic drr_valid, cmd_take, cmd_valid, ser_bit, ser_valid, ser_busy;
	logic [7:0] resp_ctrl, resp_src, resp_dst, drr_dst, drr_id;
	logic [7:0] cmd_ctrl, cmd_src;
	logic [1:0] resp_prec, drr_prec, cmd_kind;
	logic [2:0] vd;
	int mismatches = 0, comparisons = 0, cyc = 0;
	assign vd = {rx_dup, rx_accept, rx_discard};
	link_control_field_handler DUT (.*);
	peer_station peer (.*);
	always #50 clk = ~clk;
	task chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	// one destination of a received unit, once the slot is free or after 20 cycles
	task rx(input logic f, input logic [7:0] s, d, input logic [1:0] k,
		input logic [7:0] c, input logic a, input logic [7:0] n);
		repeat (20) if (resp_valid) @(posedge clk);
		@(posedge clk);
		{rx_valid, rx_first, rx_src, rx_dst} <= {1'b1, f, s, d};
		{rx_kind, rx_ctrl, rx_acked, rx_info_len} <= {k, c, a, n};
		@(posedge clk);
		rx_valid <= 1'b0;
		#1;
	endtask
	task fin(input int n);
		$display("test %0d done", n);
	endtask
	task test_done();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			mismatches++;
			test_done();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(4'h0, 16'h0030);
		rd(4'h1, 16'h0064);
		rd(4'h9, 16'h0000);
		wr(4'h1, 16'hffff);
		rd(4'h1, 16'h0bb8);
		wr(4'h1, 16'h0002);
		wr(4'h2, 16'h0015);
		rd(4'h2, 16'h0014);
		fin(1);
		@(posedge clk);
		{q_max_prec, q_fpo_pending} <= 3'h7;
		rx(1, 8'h10, 8'h14, `KIND_IND, 8'h13, 0, 0);
		chk(vd, 3'h2);
		chk(resp_ctrl, 8'h33);
		chk(resp_dst, 8'h10);
		chk(resp_src, 8'h15);
		chk(resp_hold, 1'b1);
		chk(resp_prec, 2'h3);
		chk(resp_after_fpo, 1'b1);
		{q_max_prec, q_fpo_pending} <= 3'h0;
		rx(1, 8'h10, 8'h14, `KIND_IND, 8'hf3, 0, 8'h04);
		chk(resp_ctrl, 8'hf3);
		chk(resp_echo, 1'b0);
		rx(1, 8'h10, 8'h80, `KIND_GRP, 8'hf3, 0, 0);
		chk(resp_valid, 1'b0);
		rx(1, 8'h10, 8'hff, `KIND_GLB, 8'he3, 0, 8'h04);
		chk(resp_ctrl, 8'he3);
		chk(resp_echo, 1'b1);
		rx(1, 8'h10, 8'h14, `KIND_IND, 8'he3, 0, 8'h81);
		chk(vd, 3'h1);
		rx(1, 8'h10, 8'h14, `KIND_IND, 8'hff, 0, 0);
		chk(vd, 3'h1);
		chk(resp_valid, 1'b0);
		rx(1, 8'h11, 8'h14, `KIND_IND, 8'hf3, 0, 0);
		chk(vd, 3'h2);
		chk(rx_is_cmd, 1'b0);
		rx(1, 8'h10, 8'h14, `KIND_IND, 8'h0b, 0, 0);
		chk(peer_busy, 1'b1);
		rx(1, 8'h10, 8'h14, `KIND_IND, 8'h23, 0, 0);
		chk(peer_busy, 1'b0);
		fin(2);
		@(posedge clk);
		stall <= 1'b1;
		wr(4'h0, 16'h0031);
		repeat (3) @(posedge clk);
		#1 chk(cmd_ctrl, 8'h0b);
		chk(cmd_kind, `KIND_GLB);
		chk(cmd_src, 8'h14);
		chk(cmd_valid, 1'b1);
		rd(4'h3, 16'h0002);
		stall <= 1'b0;
		rx(1, 8'h10, 8'h14, `KIND_IND, 8'h13, 0, 0);
		chk(vd, 3'h1);
		chk(resp_ctrl, 8'h1b);
		chk(resp_dst, 8'h10);
		repeat (20) @(posedge clk);
		stall <= 1'b1;
		wr(4'h0, 16'h0030);
		repeat (3) @(posedge clk);
		#1 chk(cmd_ctrl, 8'h23);
		stall <= 1'b0;
		repeat (8) @(posedge clk);
		stall <= 1'b1;
		wr(4'h0, 16'h0034);
		repeat (2) @(posedge clk);
		#1 chk(cmd_ctrl, 8'h0b);
		stall <= 1'b0;
		fin(3);
		rx(1, 8'h20, 8'h14, `KIND_IND, 8'h00, 1, 0);
		chk(vd, 3'h2);
		chk(drr_prec, 2'h2);
		chk(drr_id, 8'h05);
		chk(drr_dst, 8'h20);
		rx(1, 8'h20, 8'h14, `KIND_IND, 8'h00, 1, 0);
		chk(vd, 3'h5);
		repeat (3100) @(posedge clk);
		rx(1, 8'h20, 8'h14, `KIND_IND, 8'h00, 1, 0);
		chk(vd, 3'h2);
		rd(4'h4, 16'h0001);
		fin(4);
		rx(1, 8'h10, 8'h40, `KIND_IND, 8'h03, 0, 0);
		rx(0, 8'h10, 8'h40, `KIND_IND, 8'h03, 0, 0);
		chk(vd, 3'h1);
		rx(1, 8'h10, 8'h41, `KIND_IND, 8'h03, 0, 0);
		rx(0, 8'h10, 8'h42, `KIND_IND, 8'h13, 0, 0);
		chk(vd, 3'h2);
		rx(0, 8'h10, 8'h43, `KIND_IND, 8'he3, 0, 0);
		chk(vd, 3'h1);
		rd(4'h5, 16'h0006);
		fin(5);
		@(posedge clk);
		{ni_req, ni_ns, ni_nr, ni_pf, ni_group} <= {1'b1, 7'h05, 7'h09, 2'h2};
		@(posedge clk);
		{ni_req, ni_group} <= 2'h3;
		#1 chk(ni_ctrl, {7'h09, 1'b1, 7'h05, 1'b0});
		@(posedge clk);
		ni_req <= 1'b0;
		#1 chk(ni_ctrl, 16'h0100);
		repeat (20) @(posedge clk);
		fin(6);
		test_done();
	end
endmodule // tb_top
`default_nettype wire
